// *** rtl/sdram_seq_consts.svh ***
// Constants for the SDRAM page-mode sequencer.
`ifndef SDRAM_SEQ_CONSTS_SVH
`define SDRAM_SEQ_CONSTS_SVH
`define PORT_16             1'h0
`define PORT_32             1'h1
`define CAS_LATENCY_FIELD_ONE            2'h0
`define CAS_LATENCY_FIELD_TWO            2'h1
`define CMD_NOP             3'h7
`define CMD_ACTIVATE_CMD            3'h3
`define CMD_READ            3'h5
`define CMD_WRITE           3'h4
`define CMD_PRECHARGE_ALL_CMD            3'h2
`define RAS_TO_PRE_CLKS     4'h2
`define PRE_TO_ACT_CLKS     4'h2
`endif

// *** rtl/sdram_seq_pkg.sv ***
// Types for the SDRAM page-mode sequencer.
package sdram_seq_pkg;
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_RCD    = 3'b001,
        ST_BEAT   = 3'b010,
        ST_DRAIN  = 3'b011,
        ST_RAS    = 3'b100,
        ST_PRECHARGE_ALL_CMD   = 3'b101,
        ST_RP     = 3'b110,
        ST_OPEN   = 3'b111
    } state_type;
endpackage

// *** rtl/sdram_page_mode_sequencer.sv ***
// SDRAM address multiplexer and page-mode command sequencer.
`timescale 1ns/1ps
`include "sdram_seq_consts.svh"
module sdram_page_mode_sequencer #(
    parameter int BEAT_W = 4
) (
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic              port_32,
    input  wire logic [3:0]        col_lines,
    input  wire logic [1:0]        cas_latency_field,
    input  wire logic              continuous_page,
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire logic              req_write,
    input  wire logic [31:0]       req_addr,
    input  wire logic [BEAT_W-1:0] req_beats,
    input  wire logic [31:0]       req_wdata,
    output logic                   wdata_take,
    output logic                   rdata_valid,
    output logic [31:0]            rdata,
    output logic                   done,
    output logic [12:0]            sdram_addr,
    output logic                   row_strobe_n,
    output logic                   column_strobe_n,
    output logic                   write_enable_n,
    output logic [31:0]            sdram_dq_out,
    output logic                   sdram_dq_oe,
    input  wire logic [31:0]       sdram_dq_in
);
    sdram_seq_pkg::state_type state_q, state_d;
    logic [31:0]       addr_q, addr_d;
    logic [BEAT_W-1:0] left_q, left_d;
    logic [3:0]        cnt_q, cnt_d;
    logic              wr_q, wr_d;
    logic [18:0]       open_row_q, open_row_d;
    logic              open_q, open_d;
    logic [2:0]        cmd_q, cmd_d;
    logic [12:0]       a_q, a_d;
    logic [31:0]       dq_q, dq_d;
    logic              oe_q, oe_d;
    logic [5:0]        rd_pipe_q, rd_pipe_d;
    logic [31:0]       din_s1_q, din_s2_q;
    logic [31:0]       din_s1_d, din_s2_d;
    logic [31:0]       rdata_q, rdata_d;
    logic              rvalid_q, rvalid_d;
    logic              done_q, done_d;
    logic [12:0]       row_addr, col_addr;
    logic [31:0]       map_addr;
    logic              hit;
    logic [1:0]        rd_lat;
    logic [2:0]        rv_idx;
    logic [3:0]        rcd_clks;

    // Row/column pin patterns, chosen by port size and column count.
    always_comb begin
        row_addr = 13'h0000;
        col_addr = 13'h0000;
        if (port_32 == `PORT_32) begin
            // Pins 0-6 carry row 15..9 and column 2..8; pin 7 row 17 / column 16.
            row_addr[0] = map_addr[15];
            col_addr[0] = map_addr[2];
            row_addr[1] = map_addr[14];
            col_addr[1] = map_addr[3];
            row_addr[2] = map_addr[13];
            col_addr[2] = map_addr[4];
            row_addr[3] = map_addr[12];
            col_addr[3] = map_addr[5];
            row_addr[4] = map_addr[11];
            col_addr[4] = map_addr[6];
            row_addr[5] = map_addr[10];
            col_addr[5] = map_addr[7];
            row_addr[6] = map_addr[9];
            col_addr[6] = map_addr[8];
            row_addr[7] = map_addr[17];
            col_addr[7] = map_addr[16];
        end else begin
            // Pins 0-7 carry row 16..9 and column 1..8.
            row_addr[0] = map_addr[16];
            col_addr[0] = map_addr[1];
            row_addr[1] = map_addr[15];
            col_addr[1] = map_addr[2];
            row_addr[2] = map_addr[14];
            col_addr[2] = map_addr[3];
            row_addr[3] = map_addr[13];
            col_addr[3] = map_addr[4];
            row_addr[4] = map_addr[12];
            col_addr[4] = map_addr[5];
            row_addr[5] = map_addr[11];
            col_addr[5] = map_addr[6];
            row_addr[6] = map_addr[10];
            col_addr[6] = map_addr[7];
            row_addr[7] = map_addr[9];
            col_addr[7] = map_addr[8];
        end

        // Upper pins: each extra column line takes a row pin and shifts the rows above it.
        unique case ({port_32, col_lines})
            {`PORT_32, 4'h8}: begin
                // Rows 18 to 22 pass straight.
                row_addr[8]  = map_addr[18];
                row_addr[9]  = map_addr[19];
                row_addr[10] = map_addr[20];
                row_addr[11] = map_addr[21];
                row_addr[12] = map_addr[22];
            end
            {`PORT_32, 4'h9}: begin
                // Row 18 dropped; pin 8 carries column 18.
                row_addr[8]  = map_addr[19];
                row_addr[9]  = map_addr[20];
                row_addr[10] = map_addr[21];
                row_addr[11] = map_addr[22];
                row_addr[12] = map_addr[23];
                col_addr[8]  = map_addr[18];
            end
            {`PORT_32, 4'hA}: begin
                // Row 20 unused; pin 9 carries column 20.
                row_addr[8]  = map_addr[19];
                row_addr[9]  = map_addr[21];
                row_addr[10] = map_addr[22];
                row_addr[11] = map_addr[23];
                row_addr[12] = map_addr[24];
                col_addr[8]  = map_addr[18];
                col_addr[9]  = map_addr[20];
            end
            {`PORT_32, 4'hB}: begin
                // Row 22 unused; pin 10 carries column 22.
                row_addr[8]  = map_addr[19];
                row_addr[9]  = map_addr[21];
                row_addr[10] = map_addr[23];
                row_addr[11] = map_addr[24];
                row_addr[12] = map_addr[25];
                col_addr[8]  = map_addr[18];
                col_addr[9]  = map_addr[20];
                col_addr[10] = map_addr[22];
            end
            {`PORT_32, 4'hC}: begin
                // Row 24 unused; pin 11 carries column 24.
                row_addr[8]  = map_addr[19];
                row_addr[9]  = map_addr[21];
                row_addr[10] = map_addr[23];
                row_addr[11] = map_addr[25];
                row_addr[12] = map_addr[26];
                col_addr[8]  = map_addr[18];
                col_addr[9]  = map_addr[20];
                col_addr[10] = map_addr[22];
                col_addr[11] = map_addr[24];
            end
            {`PORT_16, 4'hC}: begin
                // Odd columns 17 to 23 on pins 8 to 11; row 25 on pin 12.
                row_addr[8]  = map_addr[18];
                row_addr[9]  = map_addr[20];
                row_addr[10] = map_addr[22];
                row_addr[11] = map_addr[24];
                row_addr[12] = map_addr[25];
                col_addr[8]  = map_addr[17];
                col_addr[9]  = map_addr[19];
                col_addr[10] = map_addr[21];
                col_addr[11] = map_addr[23];
            end
            {`PORT_16, 4'hD}: begin
                // As twelve columns, plus column 25 where row 26 sits.
                row_addr[8]  = map_addr[18];
                row_addr[9]  = map_addr[20];
                row_addr[10] = map_addr[22];
                row_addr[11] = map_addr[24];
                row_addr[12] = map_addr[26];
                col_addr[8]  = map_addr[17];
                col_addr[9]  = map_addr[19];
                col_addr[10] = map_addr[21];
                col_addr[11] = map_addr[23];
                col_addr[12] = map_addr[25];
            end
            default: begin
                // Other geometries are not mapped here; the upper pins stay low for them.
                row_addr[12:8] = 5'h00;
            end
        endcase
    end

    // Beats take columns from the stepped address; the activate takes its row from the request.
    assign map_addr = (state_q == sdram_seq_pkg::ST_BEAT) ? addr_q : req_addr;
    assign hit      = open_q && (req_addr[31:13] == open_row_q);
    assign rd_lat   = cas_latency_field + 2'h1;
    // Valid trails the read by the latency, two synchroniser stages and the output register.
    assign rv_idx   = {1'b0, rd_lat} + 3'h2;
    // Latency field 01 gives two clocks; activate-to-column wait is latency less one.
    assign rcd_clks = {2'h0, rd_lat} - 4'h1;

    always_comb begin
        state_d    = state_q;
        addr_d     = addr_q;
        left_d     = left_q;
        cnt_d      = cnt_q;
        wr_d       = wr_q;
        open_row_d = open_row_q;
        open_d     = open_q;
        cmd_d      = `CMD_NOP;
        a_d        = a_q;
        dq_d       = dq_q;
        oe_d       = 1'b0;
        done_d     = 1'b0;
        rd_pipe_d  = {rd_pipe_q[4:0], 1'b0};
        req_ready  = 1'b0;
        wdata_take = 1'b0;
        unique case (state_q)
            sdram_seq_pkg::ST_IDLE, sdram_seq_pkg::ST_OPEN: begin
                if (req_valid && state_q == sdram_seq_pkg::ST_OPEN && hit) begin
                    // Page hit: column only, no activate.
                    req_ready = 1'b1;
                    addr_d    = req_addr;
                    wr_d      = req_write;
                    left_d    = req_beats;
                    state_d   = sdram_seq_pkg::ST_BEAT;
                end else if (state_q == sdram_seq_pkg::ST_OPEN) begin
                    cmd_d   = `CMD_PRECHARGE_ALL_CMD;
                    open_d  = 1'b0;
                    cnt_d   = `PRE_TO_ACT_CLKS;
                    state_d = sdram_seq_pkg::ST_RP;
                end else if (req_valid) begin
                    req_ready  = 1'b1;
                    addr_d     = req_addr;
                    wr_d       = req_write;
                    left_d     = req_beats;
                    cmd_d      = `CMD_ACTIVATE_CMD;
                    a_d        = row_addr;
                    open_row_d = req_addr[31:13];
                    open_d     = 1'b1;
                    cnt_d      = rcd_clks;
                    state_d    = (rcd_clks == 4'h0) ? sdram_seq_pkg::ST_BEAT : sdram_seq_pkg::ST_RCD;
                end
            end
            sdram_seq_pkg::ST_RCD: begin
                cnt_d = cnt_q - 4'h1;
                if (cnt_q <= 4'h1) begin
                    state_d = sdram_seq_pkg::ST_BEAT;
                end
            end
            sdram_seq_pkg::ST_BEAT: begin
                // One command and column per clock, address stepped here.
                cmd_d  = wr_q ? `CMD_WRITE : `CMD_READ;
                a_d    = 13'h0000;
                for (int i = 0; i < 13; i++) begin
                    a_d[i] = col_addr[i];
                end
                addr_d = addr_q + (port_32 ? 32'h4 : 32'h2);
                if (wr_q) begin
                    wdata_take = 1'b1;
                    dq_d       = req_wdata;
                    oe_d       = 1'b1;
                end else begin
                    rd_pipe_d[0] = 1'b1;
                end
                left_d = left_q - 1'b1;
                if (left_q <= 1) begin
                    cnt_d   = wr_q ? `RAS_TO_PRE_CLKS : {2'h0, rd_lat};
                    state_d = sdram_seq_pkg::ST_DRAIN;
                end
            end
            sdram_seq_pkg::ST_DRAIN: begin
                // Reads idle until last data returns.
                cnt_d = cnt_q - 4'h1;
                if (cnt_q <= 4'h1) begin
                    done_d = 1'b1;
                    state_d = continuous_page ? sdram_seq_pkg::ST_OPEN : sdram_seq_pkg::ST_PRECHARGE_ALL_CMD;
                end
            end
            sdram_seq_pkg::ST_PRECHARGE_ALL_CMD: begin
                cmd_d   = `CMD_PRECHARGE_ALL_CMD;
                open_d  = 1'b0;
                cnt_d   = `PRE_TO_ACT_CLKS;
                state_d = sdram_seq_pkg::ST_RP;
            end
            sdram_seq_pkg::ST_RP, sdram_seq_pkg::ST_RAS: begin
                // Idle clocks so no activate comes before precharge recovery.
                cnt_d = cnt_q - 4'h1;
                if (cnt_q <= 4'h1) begin
                    state_d = sdram_seq_pkg::ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q    <= sdram_seq_pkg::ST_IDLE;
            addr_q     <= 32'h0000_0000;
            left_q     <= '0;
            cnt_q      <= 4'h0;
            wr_q       <= 1'b0;
            open_row_q <= 19'h0;
            open_q     <= 1'b0;
            cmd_q      <= `CMD_NOP;
            a_q        <= 13'h0000;
            dq_q       <= 32'h0000_0000;
            oe_q       <= 1'b0;
            rd_pipe_q  <= 6'h00;
            done_q     <= 1'b0;
        end else begin
            state_q    <= state_d;
            addr_q     <= addr_d;
            left_q     <= left_d;
            cnt_q      <= cnt_d;
            wr_q       <= wr_d;
            open_row_q <= open_row_d;
            open_q     <= open_d;
            cmd_q      <= cmd_d;
            a_q        <= a_d;
            dq_q       <= dq_d;
            oe_q       <= oe_d;
            rd_pipe_q  <= rd_pipe_d;
            done_q     <= done_d;
        end
    end

    // Read data passes two flip-flops since it arrives from pins, then the output register.
    always_comb begin
        din_s1_d = sdram_dq_in;
        din_s2_d = din_s1_q;
        rdata_d  = din_s2_q;
        rvalid_d = rd_pipe_q[rv_idx];
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            din_s1_q <= 32'h0000_0000;
            din_s2_q <= 32'h0000_0000;
            rdata_q  <= 32'h0000_0000;
            rvalid_q <= 1'b0;
        end else begin
            din_s1_q <= din_s1_d;
            din_s2_q <= din_s2_d;
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign rdata_valid     = rvalid_q;
    assign rdata           = rdata_q;
    assign done            = done_q;
    assign sdram_addr      = a_q;
    assign row_strobe_n    = cmd_q[2];
    assign column_strobe_n = cmd_q[1];
    assign write_enable_n  = cmd_q[0];
    assign sdram_dq_out    = dq_q;
    assign sdram_dq_oe     = oe_q;
endmodule

// *** verification/sdram_seq_sva.sv ***
// Concurrent checks on the sequencer's command and data pins.
`timescale 1ns/1ps
`include "sdram_seq_consts.svh"
module sdram_seq_sva (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        port_32,
    input wire logic [3:0]  col_lines,
    input wire logic [1:0]  cas_latency_field,
    input wire logic        continuous_page,
    input wire logic        req_valid,
    input wire logic        req_ready,
    input wire logic [12:0] sdram_addr,
    input wire logic        row_strobe_n,
    input wire logic        column_strobe_n,
    input wire logic        write_enable_n,
    input wire logic        sdram_dq_oe
);
    wire logic [2:0] cmd = {row_strobe_n, column_strobe_n, write_enable_n};
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_take_activates: assert property (req_valid && req_ready && !continuous_page |=> cmd == `CMD_ACTIVATE_CMD)
        else $error("take not followed by activate");
    a_rcd_one: assert property (cmd == `CMD_ACTIVATE_CMD && cas_latency_field == 2'h0 |=> cmd inside {`CMD_READ, `CMD_WRITE})
        else $error("latency one access not right after activate");
    a_rcd_two: assert property (cmd == `CMD_ACTIVATE_CMD && cas_latency_field == 2'h1 |=> cmd == `CMD_NOP ##1 cmd inside {`CMD_READ, `CMD_WRITE})
        else $error("latency two access delay wrong");
    a_write_data: assert property (cmd == `CMD_WRITE |-> sdram_dq_oe)
        else $error("write without driven data");
    a_precharge_all_cmd_idle: assert property (cmd == `CMD_PRECHARGE_ALL_CMD |=> (cmd == `CMD_NOP)[*2])
        else $error("activate too soon after precharge");
    a_write_drain: assert property (cmd == `CMD_WRITE ##1 (cmd == `CMD_NOP && !continuous_page) |=> cmd == `CMD_NOP ##1 cmd == `CMD_PRECHARGE_ALL_CMD)
        else $error("write not closed by precharge");
    a_read_drain: assert property ($past(cmd) == `CMD_READ && cmd == `CMD_NOP && cas_latency_field == 2'h1 && !continuous_page
        |=> cmd == `CMD_NOP ##1 cmd == `CMD_PRECHARGE_ALL_CMD)
        else $error("read precharge timing wrong");
    a_beat_step: assert property (cmd == `CMD_READ && $past(cmd) == `CMD_READ && port_32 && col_lines == 4'h8
        |-> sdram_addr == $past(sdram_addr) + 13'h1)
        else $error("beat column did not step");
    c_lat_three: cover property (cmd == `CMD_ACTIVATE_CMD && cas_latency_field == 2'h2);
    c_page_hit: cover property (continuous_page && req_valid && req_ready ##1 cmd == `CMD_READ);
    c_write_precharge_all_cmd: cover property (cmd == `CMD_WRITE ##3 cmd == `CMD_PRECHARGE_ALL_CMD);
endmodule
bind sdram_page_mode_sequencer sdram_seq_sva chk (.clk_sys, .rst, .port_32, .col_lines, .cas_latency_field,
    .continuous_page, .req_valid, .req_ready, .sdram_addr, .row_strobe_n, .column_strobe_n, .write_enable_n, .sdram_dq_oe);

// *** verification/sdram_model.sv ***
// Behavioural SDRAM returning an address-derived word per read command.
`timescale 1ns/1ps
`include "sdram_seq_consts.svh"
module sdram_model (
    input  wire logic        clk_sys,
    input  wire logic [1:0]  cas_latency_field,
    input  wire logic        row_strobe_n,
    input  wire logic        column_strobe_n,
    input  wire logic        write_enable_n,
    input  wire logic [12:0] sdram_addr,
    output logic [31:0]      sdram_dq_in
);
    logic [31:0] word_q [1:3];
    logic [3:1]  hit_q = '0;
    logic [31:0] last_q = '0;
    int          lat;
    // One word per read command only, as with the device burst turned off.
    always @(posedge clk_sys) begin
        hit_q <= {hit_q[2:1], {row_strobe_n, column_strobe_n, write_enable_n} == `CMD_READ};
        word_q[1] <= {19'h2B3C5, sdram_addr};
        word_q[2] <= word_q[1];
        word_q[3] <= word_q[2];
        if (hit_q[lat]) last_q <= word_q[lat];
    end
    // A released bus shows the inverse of the last word, so stale data never passes.
    always_comb begin
        lat = (cas_latency_field == 2'h0) ? 1 : int'(cas_latency_field) + 1;
        sdram_dq_in = hit_q[lat] ? word_q[lat] : ~last_q;
    end
endmodule

// *** verification/sdram_page_mode_sequencer_tb_top.sv ***
// Self-checking bench for the SDRAM page-mode sequencer.
`timescale 1ns/1ps
`include "sdram_seq_consts.svh"
module sdram_page_mode_sequencer_tb_top;
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin bad_count++; $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        port_32, continuous_page, req_valid, req_write, req_ready, wdata_take, rdata_valid, done;
    logic        row_strobe_n, column_strobe_n, write_enable_n, sdram_dq_oe;
    logic [3:0]  col_lines, req_beats;
    logic [1:0]  cas_latency_field;
    logic [12:0] sdram_addr, row_seen;
    logic [12:0] col_q[$];
    logic [31:0] req_addr, req_wdata, rdata, sdram_dq_out, sdram_dq_in;
    logic [31:0] wd_q[$], rd_q[$];
    logic [4:0]  cfg [7] = '{5'h0C, 5'h0D, 5'h18, 5'h19, 5'h1A, 5'h1B, 5'h1C};
    int          bad_count, n_tests, n_act, n_precharge_all_cmd;
    wire logic [2:0] cmd = {row_strobe_n, column_strobe_n, write_enable_n};
    sdram_page_mode_sequencer dut (.clk_sys, .rst, .port_32, .col_lines, .cas_latency_field, .continuous_page, .req_valid,
        .req_ready, .req_write, .req_addr, .req_beats, .req_wdata, .wdata_take, .rdata_valid, .rdata, .done, .sdram_addr,
        .row_strobe_n, .column_strobe_n, .write_enable_n, .sdram_dq_out, .sdram_dq_oe, .sdram_dq_in);
    sdram_model sdram (.clk_sys, .cas_latency_field, .row_strobe_n, .column_strobe_n, .write_enable_n, .sdram_addr,
        .sdram_dq_in);
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (wdata_take === 1'b1) req_wdata <= req_wdata + 32'h1;
    always @(posedge clk_sys) begin
        if (cmd === `CMD_ACTIVATE_CMD) begin
            n_act++;
            row_seen = sdram_addr;
        end
        if (cmd === `CMD_PRECHARGE_ALL_CMD) n_precharge_all_cmd++;
        if (cmd === `CMD_READ || cmd === `CMD_WRITE) col_q.push_back(sdram_addr);
        if (cmd === `CMD_WRITE) wd_q.push_back(sdram_dq_out);
        if (rdata_valid === 1'b1) rd_q.push_back(rdata);
    end
    function automatic logic [12:0] map(input logic [31:0] a, input int o, input int n, input bit col);
        logic [12:0] r;
        int s;
        for (int k = 0; k < 13; k++) begin
            if (col) s = (k < 8 - o) ? k + 1 + o : (k < 8) ? 16 : 2 * k + 1 + o;
            else s = (k < 8 - o) ? 16 - o - k : (k < 8) ? 17 : (k < n) ? 2 * k + 2 + o : o + n + k + 1;
            r[k] = (col && k >= n) ? 1'b0 : a[s];
        end
        return r;
    endfunction
    task automatic clear;
        n_act = 0;
        n_precharge_all_cmd = 0;
        col_q.delete();
        wd_q.delete();
        rd_q.delete();
    endtask
    task automatic req(input logic w, input logic [31:0] a, input logic [3:0] b);
        int k;
        req_write = w;
        req_addr = a;
        req_beats = b;
        req_valid = 1'b1;
        #1;
        for (k = 0; k < 60 && req_ready !== 1'b1; k++) begin
            @(posedge clk_sys);
            #1;
        end
        @(posedge clk_sys);
        #1;
    endtask
    // Waits out the drain, precharge and idle clocks so trailing read words are collected.
    task automatic fin;
        int k;
        req_valid = 1'b0;
        for (k = 0; k < 60 && done !== 1'b1; k++) begin
            @(posedge clk_sys);
            #1;
        end
        `CHK("done", 1'b1, done)
        repeat (8) @(posedge clk_sys);
        #1;
    endtask
    task automatic t_map;
        logic [31:0] a;
        for (int i = 0; i < 14; i++) begin
            a = (i % 2) ? 32'hD294_C56B : 32'h2D6B_3A94;
            port_32 = cfg[i / 2][4];
            col_lines = cfg[i / 2][3:0];
            clear;
            req_wdata = a;
            req(1'b1, a, 4'h1);
            fin;
            `CHK("row", map(a, port_32, col_lines, 0), row_seen)
            `CHK("col", map(a, port_32, col_lines, 1), col_q[0] & ((13'h1 << col_lines) - 13'h1))
            `CHK("wdat", a, wd_q[0])
        end
    endtask
    task automatic t_burst(input logic [1:0] lat);
        cas_latency_field = lat;
        port_32 = 1'b1;
        col_lines = 4'h8;
        clear;
        req_wdata = 32'h1000_0000;
        req(1'b1, 32'h0000_0100, 4'h3);
        fin;
        `CHK("act", 1, n_act)
        `CHK("precharge_all_cmd", 1, n_precharge_all_cmd)
        for (int i = 0; i < 3; i++) begin
            `CHK("wdat", 32'h1000_0000 + i, wd_q[i])
            `CHK("wcol", 13'h40 + i, col_q[i])
        end
        clear;
        req(1'b0, 32'h0000_0100, 4'h4);
        fin;
        `CHK("ract", 1, n_act + n_precharge_all_cmd - 1)
        for (int i = 0; i < 4; i++) `CHK("rdat", {19'h2B3C5, 13'h40 + 13'(i)}, rd_q[i])
    endtask
    task automatic t_hit;
        continuous_page = 1'b1;
        cas_latency_field = 2'h1;
        clear;
        req(1'b0, 32'h0000_0100, 4'h1);
        req(1'b0, 32'h0000_0108, 4'h1);
        req(1'b1, 32'h0001_0000, 4'h1);
        fin;
        `CHK("hact", 2, n_act)
        `CHK("hpall", 2, n_precharge_all_cmd)
        `CHK("hcol", 13'h42, col_q[1])
        `CHK("hdat", {19'h2B3C5, 13'h42}, rd_q[1])
    endtask
    task results;
        $display("Tests %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #100000;
        bad_count++;
        results;
    end
    initial begin
        {port_32, continuous_page, req_valid, req_write} = '0;
        col_lines = 4'h8;
        cas_latency_field = 2'h1;
        req_addr = '0;
        req_beats = 4'h1;
        req_wdata = '0;
        repeat (20) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        t_map;
        for (int l = 0; l < 3; l++) t_burst(2'(l));
        t_hit;
        results;
    end
endmodule
